// *** hw/audio_input_control_pkg.sv ***
package audio_input_control_pkg;

  typedef enum logic [2:0] {
    FMT_RJ24 = 3'h0,
    FMT_RJ20 = 3'h1,
    FMT_RJ18 = 3'h2,
    FMT_RJ16 = 3'h3,
    FMT_I2S  = 3'h4,
    FMT_LJ   = 3'h5
  } serial_word_format_e;

  typedef struct packed {
    logic       dc_filter_skip;
    logic       channel_source_choice;
    logic       rate_speed_select;
    logic [2:0] serial_word_format;
  } audio_config_s;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } reg_write_s;

endpackage

// *** hw/audio_input_control_regs.sv ***
`timescale 1ns/100ps
`include "audio_input_control_regs.svh"

// Functional notes
// - Config bit 7 low keeps the dc filter in path; high skips it.
// - Config bit 6 picks the slot: 0 the i2c id, 1 the slot field.
// - Config bit 3 selects single speed at 0 or double speed at 1.
// - Config bits 2:0 select the serial word format, I2S 100 at reset.
// - Mute bit 4 high ramps the volume down then plays idle audio.
// - Channel source 1 plays the channel in slot bits 2:0, reset 0.
// - A volume code below 0x07 acts as a set mute bit.
module audio_input_control_regs
  import audio_input_control_pkg::*;
#(
  parameter int SAMPLE_W = 24
) (
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  input  wire reg_write_s          reg_wr_i,
  input  wire logic [7:0]          reg_rd_addr_i,
  output logic [7:0]               reg_rdata_o,
  input  wire logic [2:0]          i2c_id_i,
  input  wire logic [7:0]          volume_code_i,
  input  wire logic [SAMPLE_W-1:0] sample_i,
  input  wire logic                sample_valid_i,
  output logic [SAMPLE_W-1:0]      sample_o,
  output logic                     sample_valid_o,
  output audio_config_s            config_o,
  output logic [2:0]               playback_slot_o,
  output logic                     mute_active_o,
  output logic                     mute_idle_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] config_reg;
  logic [7:0] mute_slot_reg;
  wire        wr_config    = reg_wr_i.wr && reg_wr_i.addr == `AIC_ADDR_CONFIG;
  wire        wr_mute_slot = reg_wr_i.wr &&
                             reg_wr_i.addr == `AIC_ADDR_MUTE_SLOT;

  // reserved bits are stored and read back as written; host keeps them legal
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      config_reg    <= `AIC_CONFIG_RESET;
      mute_slot_reg <= `AIC_MUTE_SLOT_RESET;
    end else begin
      if (wr_config) begin
        config_reg <= reg_wr_i.wdata;
      end
      if (wr_mute_slot) begin
        mute_slot_reg <= reg_wr_i.wdata;
      end
    end
  end

  wire rd_config    = reg_rd_addr_i == `AIC_ADDR_CONFIG;
  wire rd_mute_slot = reg_rd_addr_i == `AIC_ADDR_MUTE_SLOT;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (rd_config) begin
      reg_rdata_o <= config_reg;
    end else if (rd_mute_slot) begin
      reg_rdata_o <= mute_slot_reg;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire       filter_skip = config_reg[`AIC_BIT_FILTER_SKIP];
  wire       chan_src    = config_reg[`AIC_BIT_CHAN_SRC];
  wire [2:0] slot_field  = mute_slot_reg[`AIC_SLOT_MSB:0];

  assign config_o.dc_filter_skip        = filter_skip;
  assign config_o.channel_source_choice = chan_src;
  assign config_o.rate_speed_select     = config_reg[`AIC_BIT_RATE];
  assign config_o.serial_word_format    =
    config_reg[`AIC_FMT_MSB:0];
  // slot follows a register write at once, no frame alignment here
  assign playback_slot_o =
    chan_src ? slot_field : i2c_id_i;

  wire mute_req = mute_slot_reg[`AIC_BIT_MUTE] ||
                  (volume_code_i < `AIC_VOL_MUTE_BELOW);
  assign mute_active_o = mute_req;

  ////////////////////////////////////////////////////////////////////////////
  // one-pole dc tracker; corner is fs / 2^shift, low enough for audio
  function automatic logic [SAMPLE_W-1:0] sat(input logic [SAMPLE_W:0] v);
    logic [SAMPLE_W-1:0] r;
    r = v[SAMPLE_W-1:0];
    if (v[SAMPLE_W] != v[SAMPLE_W-1]) begin
      r = {v[SAMPLE_W], {(SAMPLE_W-1){~v[SAMPLE_W]}}};
    end
    return r;
  endfunction

  logic signed [SAMPLE_W+`AIC_DC_SHIFT-1:0] dc_acc_reg;
  wire  signed [SAMPLE_W-1:0] dc_est =
    dc_acc_reg[SAMPLE_W+`AIC_DC_SHIFT-1:`AIC_DC_SHIFT];
  wire  signed [SAMPLE_W:0]   hp_diff =
    {sample_i[SAMPLE_W-1], sample_i} - {dc_est[SAMPLE_W-1], dc_est};
  wire  signed [SAMPLE_W+`AIC_DC_SHIFT-1:0] dc_acc_next =
    dc_acc_reg + (SAMPLE_W+`AIC_DC_SHIFT)'(hp_diff);
  wire  [SAMPLE_W-1:0] filtered = filter_skip ? sample_i : sat(hp_diff);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dc_acc_reg <= '0;
    end else if (sample_valid_i) begin
      dc_acc_reg <= dc_acc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ramp halves the level once per sample, abrupt cuts would click
  logic [4:0] ramp_reg;
  wire  [4:0] ramp_next =
    (mute_req && ramp_reg != `AIC_RAMP_STEPS) ? ramp_reg + 5'h01 :
    (!mute_req && ramp_reg != 5'h00)          ? ramp_reg - 5'h01 : ramp_reg;
  wire        idle = ramp_reg == `AIC_RAMP_STEPS;
  wire  [SAMPLE_W-1:0] ramped = idle ? '0 :
    SAMPLE_W'($signed(filtered) >>> ramp_reg);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ramp_reg       <= 5'h00;
      sample_o       <= '0;
      sample_valid_o <= 1'b0;
    end else begin
      sample_valid_o <= sample_valid_i;
      if (sample_valid_i) begin
        ramp_reg <= ramp_next;
        sample_o <= ramped;
      end
    end
  end
  assign mute_idle_o = idle;

  ////////////////////////////////////////////////////////////////////////////
  a_config_write: assert property (
    @(posedge clk_i) disable iff (srst_i)
    wr_config |=> config_o.dc_filter_skip ==
      $past(reg_wr_i.wdata[`AIC_BIT_FILTER_SKIP]))
    else $error("filter skip did not follow write");

  // reset checks carry no disable, they must see the reset itself
  a_reset_format: assert property (
    @(posedge clk_i)
    srst_i |=> config_o.serial_word_format == FMT_I2S)
    else $error("format not i2s after reset");

  a_reset_slot: assert property (
    @(posedge clk_i)
    srst_i |=> slot_field == 3'h0 && !config_o.channel_source_choice)
    else $error("slot field not zero after reset");

  a_reset_defaults: assert property (
    @(posedge clk_i)
    srst_i |=> !config_o.dc_filter_skip && !config_o.rate_speed_select &&
      !mute_idle_o && !mute_slot_reg[`AIC_BIT_MUTE])
    else $error("control defaults wrong after reset");

  a_rate_write: assert property (
    @(posedge clk_i) disable iff (srst_i)
    wr_config |=> config_o.rate_speed_select ==
      $past(reg_wr_i.wdata[`AIC_BIT_RATE]))
    else $error("rate select did not follow write");

  a_format_write: assert property (
    @(posedge clk_i) disable iff (srst_i)
    wr_config |=> config_o.serial_word_format ==
      $past(reg_wr_i.wdata[`AIC_FMT_MSB:0]))
    else $error("format did not follow write");

  a_slot_source: assert property (
    @(posedge clk_i) disable iff (srst_i)
    playback_slot_o ==
      (config_reg[`AIC_BIT_CHAN_SRC] ? slot_field : i2c_id_i))
    else $error("playback slot source wrong");

  a_slot_write: assert property (
    @(posedge clk_i) disable iff (srst_i)
    wr_mute_slot && chan_src |=> playback_slot_o ==
      $past(reg_wr_i.wdata[`AIC_SLOT_MSB:0]))
    else $error("slot field write not played");

  a_volume_mute: assert property (
    @(posedge clk_i) disable iff (srst_i)
    volume_code_i < `AIC_VOL_MUTE_BELOW |-> mute_active_o)
    else $error("low volume did not mute");

  a_mute_write: assert property (
    @(posedge clk_i) disable iff (srst_i)
    wr_mute_slot && reg_wr_i.wdata[`AIC_BIT_MUTE] |=> mute_active_o)
    else $error("mute bit write did not mute");

  a_bypass_pass: assert property (
    @(posedge clk_i) disable iff (srst_i)
    sample_valid_i && filter_skip && ramp_reg == 5'h00
      |=> sample_o == $past(sample_i) && sample_valid_o)
    else $error("bypass did not pass sample");

  sequence s_muted_samples;
    (mute_req && sample_valid_i)[*8];
  endsequence
  a_mute_ramp: assert property (
    @(posedge clk_i) disable iff (srst_i)
    ramp_reg == 5'h00 ##0 s_muted_samples |=> ramp_reg == 5'h08)
    else $error("mute ramp not stepping");

  a_unmute_ramp: assert property (
    @(posedge clk_i) disable iff (srst_i)
    !mute_req && sample_valid_i && ramp_reg != 5'h00
      |=> ramp_reg == $past(ramp_reg) - 5'h01)
    else $error("unmute ramp not stepping back");

  a_idle_hold: assert property (
    @(posedge clk_i) disable iff (srst_i)
    sample_valid_i && mute_req && idle |=> mute_idle_o)
    else $error("idle left while still muted");

  a_idle_zero: assert property (
    @(posedge clk_i) disable iff (srst_i)
    sample_valid_i && idle |=> sample_o == '0)
    else $error("idle output not zero");

  a_dc_track: assert property (
    @(posedge clk_i) disable iff (srst_i)
    sample_valid_i |=> dc_acc_reg == $past(dc_acc_next))
    else $error("dc tracker not updated");

endmodule

// *** hw/audio_input_control_regs.svh ***
`ifndef AUDIO_INPUT_CONTROL_REGS_SVH
`define AUDIO_INPUT_CONTROL_REGS_SVH

`define AIC_ADDR_CONFIG     8'h02
`define AIC_ADDR_MUTE_SLOT  8'h03
`define AIC_CONFIG_RESET    8'h04
`define AIC_MUTE_SLOT_RESET 8'h80
`define AIC_BIT_FILTER_SKIP 7
`define AIC_BIT_CHAN_SRC    6
`define AIC_BIT_RATE        3
`define AIC_FMT_MSB         2
`define AIC_BIT_MUTE        4
`define AIC_SLOT_MSB        2
`define AIC_VOL_MUTE_BELOW  8'h07
`define AIC_DC_SHIFT        10
`define AIC_RAMP_STEPS      5'h18

`endif

// *** verification/host_model.sv ***
`timescale 1ns/100ps
module host_model
  import audio_input_control_pkg::*;
(
  input  wire logic clk_i,
  output reg_write_s wr_o
);
  initial wr_o = '0;
  // reserved fields are forced so callers cannot break them
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 8'h02) v = v & 8'hcf;
    if (a == 8'h03) v = (v & 8'h17) | 8'h80;
    @(negedge clk_i);
    wr_o = '{addr: a, wr: 1'b1, wdata: v};
    @(negedge clk_i);
    wr_o.wr = 1'b0;
  endtask
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  import audio_input_control_pkg::*;
  logic          clk, srst, vin, vout, mact, midle;
  reg_write_s    wr;
  logic [7:0]    ra, rdata, vol;
  logic [2:0]    id, slot;
  logic [23:0]   sin, sout;
  audio_config_s cfg;
  int            n_fail, total_checks;
  audio_input_control_regs audio_input_control_regs_inst (
    .clk_i(clk), .srst_i(srst), .reg_wr_i(wr), .reg_rd_addr_i(ra),
    .reg_rdata_o(rdata), .i2c_id_i(id), .volume_code_i(vol),
    .sample_i(sin), .sample_valid_i(vin), .sample_o(sout),
    .sample_valid_o(vout), .config_o(cfg), .playback_slot_o(slot),
    .mute_active_o(mact), .mute_idle_o(midle));
  host_model host_model_inst (.clk_i(clk), .wr_o(wr));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [23:0] s, input logic [23:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    ra = a;
    @(negedge clk);
    check(rdata, e);
  endtask
  // one sample in, output settled one edge later
  task automatic smp(input logic [23:0] x);
    @(negedge clk);
    sin = x;
    vin = 1;
    @(negedge clk);
    vin = 0;
    check(vout, 1);
  endtask
  // back-to-back samples, valid held high across n edges
  task automatic burst(input int n, input logic [23:0] x);
    @(negedge clk);
    sin = x;
    vin = 1;
    repeat (n) @(negedge clk);
    vin = 0;
    check(vout, 1);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // tests need about 330 cycles; 2000 leaves a wide margin
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1;
    vin = 0;
    sin = 0;
    ra = 0;
    vol = 8'hcf;
    id = 3'h3;
    n_fail = 0;
    total_checks = 0;
    repeat (20) @(negedge clk);
    srst = 0;
    rd(8'h02, 8'h04);
    rd(8'h03, 8'h80);
    check(slot, 3'h3);
    rd(8'h05, 8'h00);
    $display("reset test done");
    // codes 110 and 111 are never sent
    for (int f = 0; f < 6; f++) begin
      host_model_inst.write(8'h02, {4'h0, f[0], f[2:0]});
      @(negedge clk);
      check(cfg, {2'b00, f[0], f[2:0]});
      rd(8'h02, {4'h0, f[0], f[2:0]});
    end
    host_model_inst.write(8'h02, 8'h74);
    host_model_inst.write(8'h03, 8'h6d);
    @(negedge clk);
    check(slot, 3'h5);
    rd(8'h02, 8'h44);
    rd(8'h03, 8'h85);
    $display("config test done");
    host_model_inst.write(8'h02, 8'h84);
    smp(24'h12_3456);
    check(sout, 24'h12_3456);
    check(cfg.dc_filter_skip, 1);
    host_model_inst.write(8'h02, 8'h04);
    repeat (100) smp(24'h10_0000);
    check(sout < 24'h10_0000, 1);
    check(sout > 24'h00_0000, 1);
    $display("filter test done");
    host_model_inst.write(8'h03, 8'h10);
    @(negedge clk);
    check(mact, 1);
    // first eight samples back to back, then spaced ones
    burst(8, 24'h00_1000);
    repeat (15) smp(24'h00_1000);
    check(midle, 0);
    smp(24'h00_1000);
    check(midle, 1);
    // output of the step into idle is still shifted, zero comes next
    smp(24'h00_1000);
    check(sout, 0);
    check(midle, 1);
    host_model_inst.write(8'h03, 8'h00);
    @(negedge clk);
    check(mact, 0);
    smp(24'h00_1000);
    check(midle, 0);
    vol = 8'h06;
    @(negedge clk);
    check(mact, 1);
    vol = 8'h07;
    @(negedge clk);
    check(mact, 0);
    $display("mute test done");
    // reset again with both registers already back at their reset contents
    @(negedge clk);
    srst = 1;
    repeat (2) @(negedge clk);
    srst = 0;
    rd(8'h02, 8'h04);
    rd(8'h03, 8'h80);
    check(slot, 3'h3);
    check(sout, 24'h00_0000);
    check(midle, 0);
    $display("second reset test done");
    conclude();
  end
endmodule
